/* mbec_map.svh */
// Event codes, counts and reset values of the bridge event counters
`ifndef MBEC_MAP_SVH
`define MBEC_MAP_SVH
`define MBEC_NUM_CTRS       4
`define MBEC_CTR_W          48
`define MBEC_CTR_RST        48'h0
`define MBEC_CTL_DELAY      2
`define MBEC_EV_NOTHING     8'h00
`define MBEC_EV_CLOCKTICKS  8'h01
`define MBEC_EV_ING_NE      8'h10
`define MBEC_EV_ING_INS     8'h11
`define MBEC_EV_PEER_FILL   8'h14
`define MBEC_EV_LSHAR_RET   8'h17
`define MBEC_EV_RSHAR_RET   8'h18
`define MBEC_EV_LDED_RET0   8'h19
`define MBEC_EV_LDED_RET1   8'h1A
`define MBEC_EV_RDED_RET    8'h1B
`define MBEC_EV_EGR_NE      8'h23
`define MBEC_EV_EGR_FULL    8'h25
`define MBEC_EV_EGR_CRD     8'h2D
`define MBEC_EV_IO_INUSE    8'h32
`define MBEC_EV_IO_TAKEN    8'h33
`define MBEC_EV_IO_REFUSED  8'h34
`define MBEC_EV_LSHAR_TK0   8'h40
`define MBEC_EV_LSHAR_TK1   8'h41
`define MBEC_EV_RSHAR_TK0   8'h42
`define MBEC_EV_RSHAR_TK1   8'h43
`define MBEC_EV_LSHAR_BACK  8'h44
`define MBEC_EV_RSHAR_BACK  8'h45
`define MBEC_EV_LDED_TK0    8'h46
`define MBEC_EV_LDED_TK1    8'h47
`define MBEC_EV_RDED_TK0    8'h48
`define MBEC_EV_RDED_TK1    8'h49
`define MBEC_EV_LWAIT0      8'h4A
`define MBEC_EV_LWAIT1      8'h4B
`define MBEC_EV_RWAIT0      8'h4C
`define MBEC_EV_RWAIT1      8'h4D
`define MBEC_EV_EGR_IN_AD   8'h50
`define MBEC_EV_EGR_IN_AK   8'h51
`endif

/* mbec_pkg.sv */
// Types shared by the bridge event counter modules
package mbec_pkg;
   typedef logic [7:0] mbec_code_t;
   typedef logic [6:0] mbec_incr_t;
   typedef enum logic [1:0]
   {
      MBEC_OFF    = 2'b00,
      MBEC_ON     = 2'b01,
      MBEC_FROZEN = 2'b11
   } mbec_run_e;
   typedef struct packed
   {
      mbec_code_t [3:0] code;
      logic [3:0][7:0]  umask;
      logic [3:0]       en;
      logic [3:0]       clr;
      logic             g_en;
      logic             g_frz;
   } mbec_ctl_s;
endpackage

/* mbec_evt_if.sv */
// Registered event signals passed to the per-counter selectors
`timescale 1ns/1ps
interface mbec_evt_if;
   logic        ingress_not_empty;
   logic        ingress_insert;
   logic [5:0]  peer_credit_fill;
   logic [7:0]  local_shar_ret;
   logic [7:0]  remote_shar_ret;
   logic [15:0] local_ded_ret;
   logic [7:0]  remote_ded_ret;
   logic        egress_not_empty;
   logic        egress_full;
   logic        egress_credit;
   logic [7:0]  io_credit_in_use;
   logic [7:0]  io_credit_taken;
   logic [7:0]  io_credit_refused;
   logic [15:0] local_shar_taken;
   logic [15:0] remote_shar_taken;
   logic [7:0]  local_shar_back;
   logic [7:0]  remote_shar_back;
   logic [15:0] local_ded_taken;
   logic [15:0] remote_ded_taken;
   logic [15:0] local_shar_wait;
   logic [15:0] remote_shar_wait;
   logic        egress_in_ad;
   logic        egress_in_ak;
   modport src
   (
      output ingress_not_empty, ingress_insert, peer_credit_fill,
      output local_shar_ret, remote_shar_ret, local_ded_ret, remote_ded_ret,
      output egress_not_empty, egress_full, egress_credit,
      output io_credit_in_use, io_credit_taken, io_credit_refused,
      output local_shar_taken, remote_shar_taken, local_shar_back,
      output remote_shar_back, local_ded_taken, remote_ded_taken,
      output local_shar_wait, remote_shar_wait, egress_in_ad, egress_in_ak
   );
   modport sink
   (
      input ingress_not_empty, ingress_insert, peer_credit_fill,
      input local_shar_ret, remote_shar_ret, local_ded_ret, remote_ded_ret,
      input egress_not_empty, egress_full, egress_credit,
      input io_credit_in_use, io_credit_taken, io_credit_refused,
      input local_shar_taken, remote_shar_taken, local_shar_back,
      input remote_shar_back, local_ded_taken, remote_ded_taken,
      input local_shar_wait, remote_shar_wait, egress_in_ad, egress_in_ak
   );
endinterface

/* mbec_counter48.sv */
// One wrapping event counter
`timescale 1ns/1ps
`include "mbec_map.svh"
module mbec_counter48
#(
   parameter int W = `MBEC_CTR_W
)
(
   input  wire logic               clk_sys, // System clock
   input  wire logic               arst_n,  // Async reset, active low
   input  wire logic               clear,   // Zero the count
   input  wire logic               add_en,  // Counting allowed
   input  wire mbec_pkg::mbec_incr_t incr,  // Amount this cycle
   output logic [W-1:0]            value    // Count
);
   import mbec_pkg::*;

   if (W < 8 || W > 64)
      $error("mbec_counter48: width out of range");

   logic [W-1:0] value_r;

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         value_r <= W'(`MBEC_CTR_RST);
      else if (clear)
         value_r <= '0;
      else if (add_en)
         value_r <= value_r + W'(incr);
   end

   assign value = value_r;
endmodule

/* mbec_event_select.sv */
// Picks one event for one counter and yields its increment
`timescale 1ns/1ps
`include "mbec_map.svh"
module mbec_event_select
#(
   parameter int IDX = 0
)
(
   mbec_evt_if.sink                  evt,       // Registered events
   input  wire mbec_pkg::mbec_code_t code,      // Selected event
   input  wire logic [7:0]           umask,     // Sub-event mask
   output mbec_pkg::mbec_incr_t      incr,      // Increment this cycle
   output logic                      misplaced  // Event not allowed here
);
   import mbec_pkg::*;

   if (IDX < 0 || IDX >= `MBEC_NUM_CTRS)
      $error("mbec_event_select: bad counter index");

   function automatic mbec_incr_t pop8(input logic [7:0] v);
      mbec_incr_t n;
      n = '0;
      for (int b = 0; b < 8; b++)
         n = n + mbec_incr_t'(v[b]);
      return n;
   endfunction

   always_comb
   begin
      incr = '0;
      misplaced = 1'b0;
      case (code)
         `MBEC_EV_NOTHING:    incr = '0;
         `MBEC_EV_CLOCKTICKS: incr = 7'h01;
         `MBEC_EV_ING_NE:     incr = mbec_incr_t'(evt.ingress_not_empty);
         `MBEC_EV_ING_INS:    incr = mbec_incr_t'(evt.ingress_insert);
         `MBEC_EV_PEER_FILL:
            if (IDX == 0)
               incr = mbec_incr_t'(evt.peer_credit_fill);
            else
               misplaced = 1'b1;
         `MBEC_EV_LSHAR_RET:  incr = pop8(evt.local_shar_ret & umask);
         `MBEC_EV_RSHAR_RET:  incr = pop8(evt.remote_shar_ret & umask);
         `MBEC_EV_LDED_RET0:  incr = pop8(evt.local_ded_ret[7:0] & umask);
         `MBEC_EV_LDED_RET1:  incr = pop8(evt.local_ded_ret[15:8] & umask);
         `MBEC_EV_RDED_RET:   incr = pop8(evt.remote_ded_ret & umask);
         `MBEC_EV_EGR_NE, `MBEC_EV_EGR_CRD:
            if (IDX <= 1)
               incr = mbec_incr_t'(code == `MBEC_EV_EGR_NE ?
                      evt.egress_not_empty : evt.egress_credit);
            else
               misplaced = 1'b1;
         `MBEC_EV_EGR_FULL:   incr = mbec_incr_t'(evt.egress_full);
         `MBEC_EV_IO_INUSE:
            incr = mbec_incr_t'(|(evt.io_credit_in_use & umask));
         `MBEC_EV_IO_TAKEN:   incr = pop8(evt.io_credit_taken & umask);
         `MBEC_EV_IO_REFUSED: incr = pop8(evt.io_credit_refused & umask);
         `MBEC_EV_LSHAR_TK0:  incr = pop8(evt.local_shar_taken[7:0] & umask);
         `MBEC_EV_LSHAR_TK1:  incr = pop8(evt.local_shar_taken[15:8] & umask);
         `MBEC_EV_RSHAR_TK0:  incr = pop8(evt.remote_shar_taken[7:0] & umask);
         `MBEC_EV_RSHAR_TK1:  incr = pop8(evt.remote_shar_taken[15:8] & umask);
         `MBEC_EV_LSHAR_BACK: incr = pop8(evt.local_shar_back & umask);
         `MBEC_EV_RSHAR_BACK: incr = pop8(evt.remote_shar_back & umask);
         `MBEC_EV_LDED_TK0:   incr = pop8(evt.local_ded_taken[7:0] & umask);
         `MBEC_EV_LDED_TK1:   incr = pop8(evt.local_ded_taken[15:8] & umask);
         `MBEC_EV_RDED_TK0:   incr = pop8(evt.remote_ded_taken[7:0] & umask);
         `MBEC_EV_RDED_TK1:   incr = pop8(evt.remote_ded_taken[15:8] & umask);
         `MBEC_EV_LWAIT0:
            incr = mbec_incr_t'(|(evt.local_shar_wait[7:0] & umask));
         `MBEC_EV_LWAIT1:
            incr = mbec_incr_t'(|(evt.local_shar_wait[15:8] & umask));
         `MBEC_EV_RWAIT0:
            incr = mbec_incr_t'(|(evt.remote_shar_wait[7:0] & umask));
         `MBEC_EV_RWAIT1:
            incr = mbec_incr_t'(|(evt.remote_shar_wait[15:8] & umask));
         `MBEC_EV_EGR_IN_AD:  incr = mbec_incr_t'(evt.egress_in_ad);
         `MBEC_EV_EGR_IN_AK:  incr = mbec_incr_t'(evt.egress_in_ak);
         default:             incr = '0;
      endcase
   end
endmodule

/* mbec_bridge_counters.sv */
// Top of the mesh-to-I/O bridge event counters
`timescale 1ns/1ps
`include "mbec_map.svh"
// How it works
// - Four 48-bit counters, each with its own control, count almost any event.
// - Occupancy events count only on counter zero; elsewhere they are refused.
// - Code 0x1 adds one per clock tick, on any counter.
// - Code 0x10 counts ingress not-empty cycles; 0x11 counts ingress inserts.
// - Egress not-empty 0x23 and egress credits 0x2D only on counters 0-1.
// - Code 0x25 counts cycles with the egress queue full.
// - Codes 0x17 and 0x18 count local and remote shared credits returned.
// - Codes 0x19, 0x1A split local dedicated returns; 0x1B counts remote ones.
// - Code 0x32 counts credit-in-use cycles; 0x33 counts credits acquired.
// - Code 0x34 counts failed attempts to obtain a transmit credit.
// - Codes 0x40-0x41 local, 0x42-0x43 remote shared credits taken.
// - Codes 0x44 and 0x45 count local and remote shared credits handed back.
// - Codes 0x46-0x47 local, 0x48-0x49 remote dedicated credits taken.
// - Codes 0x4A-0x4B local, 0x4C-0x4D remote shared-credit wait cycles.
// - Codes 0x50 and 0x51 count egress ingress for address and ack classes.
// - Transmit credit events are filtered per message class by the unit mask.
// - Enable and freeze take effect after a short fixed delay.
// - A send into the I/O stack needs a held credit of its class first.
module mbec_bridge_counters
#(
   parameter int CTR_W = `MBEC_CTR_W
)
(
   input  wire logic                     clk_sys,           // 40 MHz clock
   input  wire logic                     arst_n,            // Async reset
   input  wire logic                     global_enable,     // Counting on
   input  wire logic                     global_freeze,     // Hold counts
   input  wire mbec_pkg::mbec_code_t [3:0] ctl_event,       // Code per ctr
   input  wire logic [3:0][7:0]          ctl_umask,         // Mask per ctr
   input  wire logic [3:0]               ctl_enable,        // Enable per ctr
   input  wire logic [3:0]               ctl_clear,         // Zero per ctr
   input  wire logic                     ingress_not_empty, // Ingress busy
   input  wire logic                     ingress_insert,    // Ingress write
   input  wire logic [5:0]               peer_credit_fill,  // Occupancy
   input  wire logic [7:0]               local_shar_ret,    // Per agent
   input  wire logic [7:0]               remote_shar_ret,   // Per agent
   input  wire logic [15:0]              local_ded_ret,     // Per source
   input  wire logic [7:0]               remote_ded_ret,    // Per source
   input  wire logic                     egress_not_empty,  // Egress busy
   input  wire logic                     egress_full,       // Egress full
   input  wire logic                     egress_credit,     // Egress credit
   input  wire logic [7:0]               io_credit_in_use,  // Per class
   input  wire logic [7:0]               io_credit_taken,   // Per class
   input  wire logic [7:0]               io_credit_refused, // Per class
   input  wire logic [7:0]               io_stack_send,     // Per class
   input  wire logic [15:0]              local_shar_taken,  // Per source
   input  wire logic [15:0]              remote_shar_taken, // Per source
   input  wire logic [7:0]               local_shar_back,   // Per agent
   input  wire logic [7:0]               remote_shar_back,  // Per agent
   input  wire logic [15:0]              local_ded_taken,   // Per source
   input  wire logic [15:0]              remote_ded_taken,  // Per source
   input  wire logic [15:0]              local_shar_wait,   // Per source
   input  wire logic [15:0]              remote_shar_wait,  // Per source
   input  wire logic                     egress_in_ad,      // AD class
   input  wire logic                     egress_in_ak,      // AK class
   input  wire logic                     fault_clear,       // Clear fault
   output logic [3:0][CTR_W-1:0]         bridge_event_counter, // Counts
   output logic [3:0]                    misplaced,         // Bad placement
   output logic                          counting,          // Running
   output logic                          credit_order_fault // Send w/o crd
);
   import mbec_pkg::*;

   if (CTR_W < 8 || CTR_W > 64)
      $error("mbec_bridge_counters: counter width out of range");

   mbec_evt_if evt_q ();

   mbec_ctl_s  ctl_in;
   mbec_ctl_s  ctl_pipe_r [`MBEC_CTL_DELAY];
   mbec_ctl_s  ctl_d;
   mbec_run_e  run_r;
   mbec_run_e  run_nxt;
   mbec_incr_t incr [`MBEC_NUM_CTRS];
   logic [3:0] misplaced_c;
   logic [3:0] misplaced_r;
   logic [7:0] send_q;
   logic       fault_r;

   // Events are registered once so every counter sees the same cycle
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         evt_q.ingress_not_empty <= 1'b0;
         evt_q.ingress_insert    <= 1'b0;
         evt_q.peer_credit_fill  <= '0;
         evt_q.local_shar_ret    <= '0;
         evt_q.remote_shar_ret   <= '0;
         evt_q.local_ded_ret     <= '0;
         evt_q.remote_ded_ret    <= '0;
         evt_q.egress_not_empty  <= 1'b0;
         evt_q.egress_full       <= 1'b0;
         evt_q.egress_credit     <= 1'b0;
         evt_q.io_credit_in_use  <= '0;
         evt_q.io_credit_taken   <= '0;
         evt_q.io_credit_refused <= '0;
         evt_q.local_shar_taken  <= '0;
         evt_q.remote_shar_taken <= '0;
         evt_q.local_shar_back   <= '0;
         evt_q.remote_shar_back  <= '0;
         evt_q.local_ded_taken   <= '0;
         evt_q.remote_ded_taken  <= '0;
         evt_q.local_shar_wait   <= '0;
         evt_q.remote_shar_wait  <= '0;
         evt_q.egress_in_ad      <= 1'b0;
         evt_q.egress_in_ak      <= 1'b0;
         send_q                  <= '0;
      end
      else
      begin
         evt_q.ingress_not_empty <= ingress_not_empty;
         evt_q.ingress_insert    <= ingress_insert;
         evt_q.peer_credit_fill  <= peer_credit_fill;
         evt_q.local_shar_ret    <= local_shar_ret;
         evt_q.remote_shar_ret   <= remote_shar_ret;
         evt_q.local_ded_ret     <= local_ded_ret;
         evt_q.remote_ded_ret    <= remote_ded_ret;
         evt_q.egress_not_empty  <= egress_not_empty;
         evt_q.egress_full       <= egress_full;
         evt_q.egress_credit     <= egress_credit;
         evt_q.io_credit_in_use  <= io_credit_in_use;
         evt_q.io_credit_taken   <= io_credit_taken;
         evt_q.io_credit_refused <= io_credit_refused;
         evt_q.local_shar_taken  <= local_shar_taken;
         evt_q.remote_shar_taken <= remote_shar_taken;
         evt_q.local_shar_back   <= local_shar_back;
         evt_q.remote_shar_back  <= remote_shar_back;
         evt_q.local_ded_taken   <= local_ded_taken;
         evt_q.remote_ded_taken  <= remote_ded_taken;
         evt_q.local_shar_wait   <= local_shar_wait;
         evt_q.remote_shar_wait  <= remote_shar_wait;
         evt_q.egress_in_ad      <= egress_in_ad;
         evt_q.egress_in_ak      <= egress_in_ak;
         send_q                  <= io_stack_send;
      end
   end

   assign ctl_in = '{code: ctl_event, umask: ctl_umask, en: ctl_enable,
                     clr: ctl_clear, g_en: global_enable,
                     g_frz: global_freeze};

   // Control passes a fixed pipeline before it acts
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int s = 0; s < `MBEC_CTL_DELAY; s++)
            ctl_pipe_r[s] <= '0;
      end
      else
      begin
         ctl_pipe_r[0] <= ctl_in;
         for (int s = 1; s < `MBEC_CTL_DELAY; s++)
            ctl_pipe_r[s] <= ctl_pipe_r[s-1];
      end
   end

   assign ctl_d = ctl_pipe_r[`MBEC_CTL_DELAY-1];

   always_comb
   begin
      run_nxt = run_r;
      case (run_r)
         MBEC_OFF:
            if (ctl_d.g_en)
               run_nxt = MBEC_ON;
         MBEC_ON:
            if (!ctl_d.g_en)
               run_nxt = MBEC_OFF;
            else if (ctl_d.g_frz)
               run_nxt = MBEC_FROZEN;
         MBEC_FROZEN:
            if (!ctl_d.g_en)
               run_nxt = MBEC_OFF;
            else if (!ctl_d.g_frz)
               run_nxt = MBEC_ON;
         default:
            run_nxt = MBEC_OFF;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         run_r <= MBEC_OFF;
      else
         run_r <= run_nxt;
   end

   assign counting = (run_r == MBEC_ON);

   // One selector and one counter per control pair
   for (genvar i = 0; i < `MBEC_NUM_CTRS; i++)
   begin : g_ctr
      mbec_event_select #(.IDX(i)) u_sel
      (
         .evt       (evt_q.sink),
         .code      (ctl_d.code[i]),
         .umask     (ctl_d.umask[i]),
         .incr      (incr[i]),
         .misplaced (misplaced_c[i])
      );
      mbec_counter48 #(.W(CTR_W)) u_cnt
      (
         .clk_sys (clk_sys),
         .arst_n  (arst_n),
         .clear   (ctl_d.clr[i]),
         .add_en  (counting && ctl_d.en[i]),
         .incr    (incr[i]),
         .value   (bridge_event_counter[i])
      );
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         misplaced_r <= '0;
      else
         misplaced_r <= misplaced_c;
   end

   assign misplaced = misplaced_r;

   // Sticky flag; a new violation wins over a clear
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
         fault_r <= 1'b0;
      else if (|(send_q & ~evt_q.io_credit_in_use))
         fault_r <= 1'b1;
      else if (fault_clear)
         fault_r <= 1'b0;
   end

   assign credit_order_fault = fault_r;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   a_tick_count: assert property
      (counting && ctl_d.en[3] && !ctl_d.clr[3] &&
       ctl_d.code[3] == `MBEC_EV_CLOCKTICKS |=> bridge_event_counter[3]
       == CTR_W'($past(bridge_event_counter[3]) + 1))
      else $error("tick event did not add one");
   a_nothing_hold: assert property
      (ctl_d.code[0] == `MBEC_EV_NOTHING && !ctl_d.clr[0]
       |=> $stable(bridge_event_counter[0]))
      else $error("idle code changed counter");
   a_occ_refused: assert property
      (ctl_d.code[2] == `MBEC_EV_PEER_FILL && !ctl_d.clr[2]
       |=> misplaced[2] && $stable(bridge_event_counter[2]))
      else $error("occupancy counted off counter zero");
   a_egress_refused: assert property
      (ctl_d.code[3] == `MBEC_EV_EGR_NE && !ctl_d.clr[3]
       |=> misplaced[3] && $stable(bridge_event_counter[3]))
      else $error("egress event counted on counter three");
   a_ingress_busy: assert property
      (counting && ctl_d.en[1] && !ctl_d.clr[1] &&
       ctl_d.code[1] == `MBEC_EV_ING_NE
       |=> bridge_event_counter[1] == CTR_W'($past(bridge_event_counter[1])
           + $past(evt_q.ingress_not_empty)))
      else $error("ingress not-empty miscounted");
   a_full_cycles: assert property
      (counting && ctl_d.en[1] && !ctl_d.clr[1] &&
       ctl_d.code[1] == `MBEC_EV_EGR_FULL && evt_q.egress_full
       |=> bridge_event_counter[1] ==
           CTR_W'($past(bridge_event_counter[1]) + 1))
      else $error("egress full cycle missed");
   a_taken_mask: assert property
      (counting && ctl_d.en[2] && !ctl_d.clr[2] &&
       ctl_d.code[2] == `MBEC_EV_IO_TAKEN
       |=> bridge_event_counter[2] == CTR_W'($past(bridge_event_counter[2])
           + $countones($past(evt_q.io_credit_taken & ctl_d.umask[2]))))
      else $error("taken credits not masked per class");
   a_counter_wrap: assert property
      (counting && ctl_d.en[3] && !ctl_d.clr[3] && &bridge_event_counter[3]
       && ctl_d.code[3] == `MBEC_EV_CLOCKTICKS
       |=> bridge_event_counter[3] == '0)
      else $error("counter did not wrap");
   a_freeze_hold: assert property
      (run_r == MBEC_FROZEN && !(|ctl_d.clr)
       |=> $stable(bridge_event_counter))
      else $error("counters moved while frozen");
   a_enable_lag: assert property
      ($rose(global_enable) && !$past(global_enable, 2) && run_r == MBEC_OFF
       && !global_freeze ##1 (global_enable && !global_freeze) [*2]
       |=> run_r == MBEC_ON ##0 $past(run_r, 2) == MBEC_OFF)
      else $error("enable delay not two stages");
   a_order_fault: assert property
      (|(send_q & ~evt_q.io_credit_in_use)
       |=> credit_order_fault)
      else $error("send without credit not flagged");
   a_fault_sticky: assert property
      (credit_order_fault && !fault_clear |=> credit_order_fault)
      else $error("credit fault dropped without a clear");

   c_counting: cover property (counting && |incr[0]);
   c_freeze: cover property (run_r == MBEC_ON ##1 run_r == MBEC_FROZEN);
   c_misplace: cover property ($rose(misplaced[2]));
   c_fault: cover property ($rose(credit_order_fault));
endmodule

/* mbec_tb.sv */
// Self-checking bench for the bridge event counters
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
   import mbec_pkg::*;
   localparam int W = 10;
   localparam logic [11:0] TAB [29] = '{12'h101, 12'h111, 12'h174,
      12'h184, 12'h193, 12'h1A2, 12'h1B4, 12'h231, 12'h251, 12'h2D1,
      12'h321, 12'h334, 12'h344, 12'h403, 12'h412, 12'h423, 12'h432,
      12'h444, 12'h454, 12'h463, 12'h472, 12'h483, 12'h492, 12'h4A1,
      12'h4B1, 12'h4C1, 12'h4D1, 12'h501, 12'h511};
   logic              clk_sys, arst_n, global_enable, global_freeze;
   logic              fault_clear, counting, credit_order_fault;
   mbec_code_t [3:0]  ctl_event;
   logic [3:0][7:0]   ctl_umask;
   logic [3:0]        ctl_enable, ctl_clear, misplaced;
   logic              ingress_not_empty, ingress_insert, egress_not_empty;
   logic              egress_full, egress_credit, egress_in_ad, egress_in_ak;
   logic [5:0]        peer_credit_fill;
   logic [7:0]        local_shar_ret, remote_shar_ret, remote_ded_ret;
   logic [7:0]        local_shar_back, remote_shar_back, io_stack_send;
   logic [7:0]        io_credit_in_use, io_credit_taken, io_credit_refused;
   logic [15:0]       local_ded_ret, local_shar_taken, remote_shar_taken;
   logic [15:0]       local_ded_taken, remote_ded_taken;
   logic [15:0]       local_shar_wait, remote_shar_wait;
   logic [3:0][W-1:0] bridge_event_counter;
   int                checks, bad_count;
   mbec_bridge_counters #(.CTR_W(W)) i_dut (.*);
   always #12.5 clk_sys = ~clk_sys;
   // Count gained by counter c over n cycles once pipelines have filled
   task automatic meas(input int c, input int n, input int per);
      logic [W-1:0] a;
      repeat (4) @(negedge clk_sys);
      a = bridge_event_counter[c];
      repeat (n) @(negedge clk_sys);
      `CHK(bridge_event_counter[c] - a, W'(n * per))
   endtask
   task automatic t_ticks;
      ctl_event[3] = 8'h01;
      meas(3, 20, 1);
      meas(0, 20, 0);
      meas(3, 1100, 1);
   endtask
   task automatic t_table;
      foreach (TAB[i])
      begin
         ctl_event[1] = TAB[i][11:4];
         if (i < 2)
            meas(1, 6, int'(TAB[i][3:0]));
         else if (i < 7)
            meas(1, 6, int'(TAB[i][3:0]));
         else if (i < 10)
            meas(1, 6, int'(TAB[i][3:0]));
         else if (i < 13)
            meas(1, 6, int'(TAB[i][3:0]));
         else if (i < 23)
            meas(1, 6, int'(TAB[i][3:0]));
         else
            meas(1, 6, int'(TAB[i][3:0]));
      end
      ctl_event[1] = 8'h00;
   endtask
   task automatic t_place;
      ctl_event = {8'h23, 8'h14, 8'h00, 8'h14};
      meas(0, 6, 5);
      meas(2, 6, 0);
      meas(3, 6, 0);
      `CHK(misplaced, 4'hC)
      ctl_event = '0;
   endtask
   task automatic t_mask;
      ctl_event[2] = 8'h33;
      ctl_umask[2] = 8'h01;
      meas(2, 6, 1);
      ctl_umask[2] = 8'h0C;
      meas(2, 6, 2);
      ctl_umask[2] = 8'hFF;
   endtask
   task automatic t_freeze;
      ctl_event[3] = 8'h01;
      global_freeze = 1'b1;
      meas(3, 10, 0);
      global_freeze = 1'b0;
      meas(3, 10, 1);
      ctl_clear[3] = 1'b1;
      repeat (4) @(negedge clk_sys);
      `CHK(bridge_event_counter[3], W'(0))
      ctl_clear[3] = 1'b0;
      `CHK(counting, 1'b1)
      global_enable = 1'b0;
      repeat (3) @(negedge clk_sys);
      `CHK(counting, 1'b0)
      meas(3, 10, 0);
      global_enable = 1'b1;
   endtask
   task automatic t_fault;
      io_stack_send = 8'h02;
      repeat (3) @(negedge clk_sys);
      `CHK(credit_order_fault, 1'b1)
      io_stack_send = 8'h00;
      fault_clear = 1'b1;
      repeat (3) @(negedge clk_sys);
      fault_clear = 1'b0;
      io_stack_send = 8'h04;
      repeat (3) @(negedge clk_sys);
      `CHK(credit_order_fault, 1'b0)
      io_stack_send = 8'h00;
   endtask
   task automatic report_and_stop;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      {clk_sys, arst_n, global_freeze, fault_clear, ctl_clear} = '0;
      {global_enable, ctl_enable, ctl_umask} = '1;
      ctl_event = '0;
      {ingress_not_empty, ingress_insert, egress_not_empty, egress_full,
         egress_credit, egress_in_ad, egress_in_ak} = '1;
      {local_shar_ret, remote_shar_ret, remote_ded_ret, local_shar_back,
         remote_shar_back, io_credit_taken, io_credit_refused} = {7{8'h0F}};
      {local_ded_ret, local_shar_taken, remote_shar_taken, local_ded_taken,
         remote_ded_taken, local_shar_wait, remote_shar_wait} = {7{16'h0307}};
      {io_credit_in_use, io_stack_send} = {8'h05, 8'h00};
      peer_credit_fill = 6'h05;
      {checks, bad_count} = '0;
      repeat (10) @(negedge clk_sys);
      arst_n = 1'b1;
      t_ticks();
      t_table();
      t_place();
      t_mask();
      t_freeze();
      t_fault();
      report_and_stop();
   end
endmodule
